/* File: hw/floppy_cfg_regs.vh */
// register indices, field positions and reset values of the floppy
// logical device configuration bank and its configuration port.
// assumes the includer works on 8-bit index/data configuration cycles.
//
// Notes on behaviour
// R01 - defaults return only on hard resets
// R02 - mode bit 0 selects enhanced mode
// R03 - mode bit 1 selects non-burst dma
// R04 - mode bits 3:2 select interface mode
// R05 - mode bit 6 selects push-pull drivers
// R06 - mode bit 7 tri-states floppy outputs
// R07 - driver controls skip parallel port pins
// R08 - option bit 0 forces drive 0 protect
// R09 - forced protect covers parallel port drive
// R10 - option bits 3:2 override density output
// R11 - drive type byte, resets to 0xff
// R12 - index 0xf3 reads zero, read-only
// R13 - drive 0 setup fields and zero bits
// R14 - setup bit 6 disables precompensation
// R15 - drive 1 setup mirrors drive 0
// R16 - drive 0 is always boot drive
// R17 - bank visible only for device 0x00
// R18 - host writes index, then data port
// R19 - strap picks base, globals relocate it
// R20 - writes to zero bits are dropped
`ifndef FLOPPY_CFG_REGS_VH
`define FLOPPY_CFG_REGS_VH

`define IDX_LDN 8'h07
`define IDX_BASE_LO 8'h26
`define IDX_BASE_HI 8'h27
`define LDN_FLOPPY 8'h00

`define IDX_MODE 8'hf0
`define IDX_OPTION 8'hf1
`define IDX_TYPE 8'hf2
`define IDX_RSVD 8'hf3
`define IDX_DRV0 8'hf4
`define IDX_DRV1 8'hf5

`define RST_MODE 8'h0e
`define RST_OPTION 8'h00
`define RST_TYPE 8'hff
`define RST_DRV 8'h00
`define RST_LDN 8'h00

`define MASK_MODE 8'hcf
`define MASK_OPTION 8'h0d
`define MASK_TYPE 8'hff
`define MASK_DRV 8'h5b

`define BASE_STRAP0 16'h03f0
`define BASE_STRAP1 16'h0370

`define MODE_ENH 0
`define MODE_NONBURST 1
`define MODE_IF_LO 2
`define MODE_IF_HI 3
`define MODE_PUSH_PULL 6
`define MODE_TRISTATE 7

`define OPT_FORCE_PROTECT 0
`define OPT_DEN_LO 2
`define OPT_DEN_HI 3
`define DEN_FORCE_ONE 2'b10
`define DEN_FORCE_ZERO 2'b11

`define DRV_TYPE_LO 0
`define DRV_TYPE_HI 1
`define DRV_RATE_LO 3
`define DRV_RATE_HI 4
`define DRV_PRECOMP_OFF 6

`endif

/* File: hw/floppy_pin_driver.v */
// output stage for the dedicated floppy pins.
// assumes the pad resolves the level from pin and enable.
`timescale 1ns/10ps
module floppy_pin_driver #(
	parameter WIDTH = 8
) (
	input wire core_clk_i,
	input wire arst_n_i,
	input wire [WIDTH-1:0] value_i,
	input wire push_pull_i,
	input wire tristate_i,
	output reg [WIDTH-1:0] pin_o,
	output reg [WIDTH-1:0] pin_oe_o
);

	always @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pin_o <= {WIDTH{1'b0}};
			pin_oe_o <= {WIDTH{1'b0}};
		end else if (tristate_i) begin
			// R06 all high-z
			pin_o <= {WIDTH{1'b0}};
			pin_oe_o <= {WIDTH{1'b0}};
		end else if (push_pull_i) begin
			// R05 push-pull drive
			pin_o <= value_i;
			pin_oe_o <= {WIDTH{1'b1}};
		end else begin
			// R05 open-drain pulls low only
			pin_o <= {WIDTH{1'b0}};
			pin_oe_o <= ~value_i;
		end
	end

endmodule

/* File: hw/floppy_logical_device_config.v */
// floppy logical device configuration bank behind an index/data port.
// assumes one-cycle synchronous io strobes; arst_n_i is the main
// power-on reset, the other hard resets arrive as synchronous levels.
`timescale 1ns/10ps
`include "floppy_cfg_regs.vh"
module floppy_logical_device_config #(
	parameter PIN_WIDTH = 8
) (
	input wire core_clk_i,
	input wire arst_n_i,
	input wire standby_por_i,
	input wire hard_reset_input_i,
	input wire soft_reset_i,
	input wire config_port_strap_i,
	input wire [15:0] io_addr_i,
	input wire io_wr_i,
	input wire io_rd_i,
	input wire [7:0] io_wdata_i,
	output reg [7:0] io_rdata_o,
	output reg io_rvalid_o,
	input wire [PIN_WIDTH-1:0] core_fdd_out_i,
	output wire [PIN_WIDTH-1:0] fdd_pin_o,
	output wire [PIN_WIDTH-1:0] fdd_pin_oe_o,
	input wire [PIN_WIDTH-1:0] core_pp_fdd_out_i,
	output reg [PIN_WIDTH-1:0] pp_fdd_pin_o,
	input wire pp_route_i,
	input wire write_protect_n_i,
	input wire drive0_select_n_i,
	input wire pp_write_protect_n_i,
	input wire pp_drive0_select_n_i,
	output reg core_write_protect_n_o,
	input wire core_density_i,
	output reg density_o,
	output reg enhanced_mode_two_o,
	output reg nonburst_dma_o,
	output reg [1:0] interface_mode_o,
	output reg [7:0] drive_type_store_o,
	output reg [1:0] drive0_type_sel_o,
	output reg [1:0] drive0_rate_table_sel_o,
	output reg drive0_precomp_disable_o,
	output reg [1:0] drive1_type_sel_o,
	output reg [1:0] drive1_rate_table_sel_o,
	output reg drive1_precomp_disable_o,
	output reg boot_drive_o
);

	// configuration port state
	reg [7:0] index_q;
	reg [7:0] ldn_q;
	reg [15:0] base_q;
	reg strap_done_q;

	// floppy bank
	reg [7:0] mode_q;
	reg [7:0] option_q;
	reg [7:0] type_q;
	reg [7:0] drv0_q;
	reg [7:0] drv1_q;

	wire hard_clear;
	wire hit_index;
	wire hit_data;
	wire wr_data;
	wire bank_sel;
	reg [7:0] rd_d;

	// masked write: bits held at zero never take a one
	function [7:0] masked;
		input [7:0] value;
		input [7:0] mask;
		begin
			masked = value & mask;
		end
	endfunction

	// density override from the two option bits
	function density_of;
		input [1:0] sel;
		input core_level;
		begin
			case (sel)
				`DEN_FORCE_ONE: density_of = 1'b1;
				`DEN_FORCE_ZERO: density_of = 1'b0;
				default: density_of = core_level;
			endcase
		end
	endfunction

	// protect is active low; force pulls it low while drive 0 selected
	function protect_n_of;
		input wp_n;
		input sel0_n;
		input force_on;
		begin
			protect_n_of = wp_n & ~(force_on & ~sel0_n);
		end
	endfunction

	// R01 hard resets only
	assign hard_clear = standby_por_i | hard_reset_input_i;

	// R18 index then data
	assign hit_index = (io_addr_i == base_q);
	assign hit_data = (io_addr_i == (base_q + 16'h0001));
	assign wr_data = io_wr_i & hit_data;

	// R17 bank only for device zero
	assign bank_sel = (ldn_q == `LDN_FLOPPY);

	// strap is sampled on the first edge after reset release and again on every hard clear, so
	// no port value ever enters the asynchronous reset branch
	always @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			strap_done_q <= 1'b0;
			base_q <= `BASE_STRAP0;
		end else if (hard_clear || !strap_done_q) begin
			// R19 strap picks base
			strap_done_q <= 1'b1;
			base_q <= config_port_strap_i ? `BASE_STRAP1 : `BASE_STRAP0;
		end else if (wr_data && index_q == `IDX_BASE_LO) begin
			// R19 relocate, even boundary
			base_q <= {base_q[15:8], io_wdata_i[7:1], 1'b0};
		end else if (wr_data && index_q == `IDX_BASE_HI) begin
			// R19 relocate high byte
			base_q <= {io_wdata_i, base_q[7:0]};
		end
	end

	// index and device number are global state; a soft reset returns
	// the index only, so a half-done access cannot land elsewhere
	always @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			index_q <= 8'h00;
		end else if (hard_clear || soft_reset_i) begin
			index_q <= 8'h00;
		end else if (io_wr_i && hit_index) begin
			// R18 index write
			index_q <= io_wdata_i;
		end
	end

	always @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ldn_q <= `RST_LDN;
		end else if (hard_clear) begin
			ldn_q <= `RST_LDN;
		end else if (wr_data && index_q == `IDX_LDN) begin
			ldn_q <= io_wdata_i;
		end
	end

	// bank registers: soft reset is deliberately absent here
	always @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			mode_q <= `RST_MODE;
			option_q <= `RST_OPTION;
			type_q <= `RST_TYPE;
			drv0_q <= `RST_DRV;
			drv1_q <= `RST_DRV;
		end else if (hard_clear) begin
			// R01 defaults on hard reset
			mode_q <= `RST_MODE;
			option_q <= `RST_OPTION;
			type_q <= `RST_TYPE;
			drv0_q <= `RST_DRV;
			drv1_q <= `RST_DRV;
		end else if (wr_data && bank_sel) begin
			// R20 zero bits dropped
			case (index_q)
				`IDX_MODE: mode_q <= masked(io_wdata_i, `MASK_MODE);
				`IDX_OPTION: option_q <= masked(io_wdata_i, `MASK_OPTION);
				// R11 full byte store
				`IDX_TYPE: type_q <= masked(io_wdata_i, `MASK_TYPE);
				// R13 drive 0 setup
				`IDX_DRV0: drv0_q <= masked(io_wdata_i, `MASK_DRV);
				// R15 drive 1 setup
				`IDX_DRV1: drv1_q <= masked(io_wdata_i, `MASK_DRV);
				// R12 reserved ignores writes
				default: mode_q <= mode_q;
			endcase
		end
	end

	// read mux for the data port
	always @* begin
		rd_d = 8'h00;
		case (index_q)
			`IDX_LDN: rd_d = ldn_q;
			`IDX_BASE_LO: rd_d = base_q[7:0];
			`IDX_BASE_HI: rd_d = base_q[15:8];
			default: rd_d = 8'h00;
		endcase
		if (bank_sel) begin
			// R17 bank visible
			case (index_q)
				`IDX_MODE: rd_d = mode_q;
				`IDX_OPTION: rd_d = option_q;
				`IDX_TYPE: rd_d = type_q;
				// R12 reads zero
				`IDX_RSVD: rd_d = 8'h00;
				`IDX_DRV0: rd_d = drv0_q;
				`IDX_DRV1: rd_d = drv1_q;
				default: rd_d = rd_d;
			endcase
		end
	end

	// read answer one edge after the strobe; the index port reads back
	always @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			io_rdata_o <= 8'h00;
			io_rvalid_o <= 1'b0;
		end else begin
			io_rvalid_o <= io_rd_i & (hit_index | hit_data);
			if (io_rd_i && hit_index) begin
				io_rdata_o <= index_q;
			end else if (io_rd_i && hit_data) begin
				io_rdata_o <= rd_d;
			end
		end
	end

	// R05 output stage
	floppy_pin_driver #(
		.WIDTH(PIN_WIDTH)
	) u_pins (
		.core_clk_i(core_clk_i),
		.arst_n_i(arst_n_i),
		.value_i(core_fdd_out_i),
		.push_pull_i(mode_q[`MODE_PUSH_PULL]),
		.tristate_i(mode_q[`MODE_TRISTATE]),
		.pin_o(fdd_pin_o),
		.pin_oe_o(fdd_pin_oe_o)
	);

	// signals into the core and out to the muxing logic
	always @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pp_fdd_pin_o <= {PIN_WIDTH{1'b0}};
			core_write_protect_n_o <= 1'b1;
			density_o <= 1'b0;
		end else begin
			// R07 parallel pins ungated
			pp_fdd_pin_o <= core_pp_fdd_out_i;
			if (pp_route_i) begin
				// R09 forced protect via parallel
				core_write_protect_n_o <= protect_n_of(
					pp_write_protect_n_i, pp_drive0_select_n_i,
					option_q[`OPT_FORCE_PROTECT]);
			end else begin
				// R08 forced protect drive 0
				core_write_protect_n_o <= protect_n_of(
					write_protect_n_i, drive0_select_n_i,
					option_q[`OPT_FORCE_PROTECT]);
			end
			// R10 density override
			density_o <= density_of(
				option_q[`OPT_DEN_HI:`OPT_DEN_LO], core_density_i);
		end
	end

	// decoded settings, one edge behind the register
	always @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			enhanced_mode_two_o <= 1'b0;
			nonburst_dma_o <= 1'b1;
			interface_mode_o <= 2'b11;
			drive_type_store_o <= `RST_TYPE;
			drive0_type_sel_o <= 2'b00;
			drive0_rate_table_sel_o <= 2'b00;
			drive0_precomp_disable_o <= 1'b0;
			drive1_type_sel_o <= 2'b00;
			drive1_rate_table_sel_o <= 2'b00;
			drive1_precomp_disable_o <= 1'b0;
			boot_drive_o <= 1'b0;
		end else begin
			// R02 floppy mode
			enhanced_mode_two_o <= mode_q[`MODE_ENH];
			// R03 dma style
			nonburst_dma_o <= mode_q[`MODE_NONBURST];
			// R04 interface mode
			interface_mode_o <= mode_q[`MODE_IF_HI:`MODE_IF_LO];
			// R11 type byte out
			drive_type_store_o <= type_q;
			// R13 drive 0 fields
			drive0_type_sel_o <= drv0_q[`DRV_TYPE_HI:`DRV_TYPE_LO];
			drive0_rate_table_sel_o <= drv0_q[`DRV_RATE_HI:`DRV_RATE_LO];
			// R14 precomp off
			drive0_precomp_disable_o <= drv0_q[`DRV_PRECOMP_OFF];
			// R15 drive 1 fields
			drive1_type_sel_o <= drv1_q[`DRV_TYPE_HI:`DRV_TYPE_LO];
			drive1_rate_table_sel_o <= drv1_q[`DRV_RATE_HI:`DRV_RATE_LO];
			// R14 precomp off
			drive1_precomp_disable_o <= drv1_q[`DRV_PRECOMP_OFF];
			// R16 boot is drive 0
			boot_drive_o <= 1'b0;
		end
	end

endmodule

/* File: sim/floppy_cfg_assertions.sv */
// port-level assertions for the floppy configuration bank.
// bound into the bank; sees its ports only.
`timescale 1ns/10ps
module floppy_cfg_assertions #(
	parameter PIN_WIDTH = 8
) (
	input wire core_clk_i,
	input wire arst_n_i,
	input wire standby_por_i,
	input wire hard_reset_input_i,
	input wire io_wr_i,
	input wire io_rd_i,
	input wire io_rvalid_o,
	input wire [PIN_WIDTH-1:0] core_fdd_out_i,
	input wire [PIN_WIDTH-1:0] fdd_pin_o,
	input wire [PIN_WIDTH-1:0] fdd_pin_oe_o,
	input wire [PIN_WIDTH-1:0] core_pp_fdd_out_i,
	input wire [PIN_WIDTH-1:0] pp_fdd_pin_o,
	input wire pp_route_i,
	input wire write_protect_n_i,
	input wire drive0_select_n_i,
	input wire pp_write_protect_n_i,
	input wire pp_drive0_select_n_i,
	input wire core_write_protect_n_o,
	input wire [1:0] interface_mode_o,
	input wire [7:0] drive_type_store_o
);
	default clocking @(posedge core_clk_i);
	endclocking
	default disable iff (!arst_n_i);
	// a quiet cycle after the clear keeps a fresh write out of view
	sequence hard_clear_s;
		(hard_reset_input_i || standby_por_i) ##1 !io_wr_i;
	endsequence
	hard_defaults_a: assert property (hard_clear_s |=>
		interface_mode_o == 2'b11 && drive_type_store_o == 8'hff)
		else $error("defaults missing after hard reset");
	read_answer_a: assert property (io_rvalid_o |-> $past(io_rd_i))
		else $error("read answer without read strobe");
	rvalid_pulse_a: assert property (
		io_rvalid_o && !io_rd_i |=> !io_rvalid_o)
		else $error("read answer longer than one cycle");
	wp_pass_a: assert property (
		!pp_route_i && drive0_select_n_i |=>
		core_write_protect_n_o == $past(write_protect_n_i))
		else $error("protect input not passed through");
	wp_parallel_a: assert property (
		pp_route_i && pp_drive0_select_n_i |=>
		core_write_protect_n_o == $past(pp_write_protect_n_i))
		else $error("parallel protect not passed through");
	pp_pins_a: assert property (
		1'b1 |=> pp_fdd_pin_o == $past(core_pp_fdd_out_i))
		else $error("parallel floppy pins gated");
	driven_pins_a: assert property (
		(fdd_pin_oe_o & (fdd_pin_o ^ $past(core_fdd_out_i))) == '0)
		else $error("driven pin shows wrong level");
	undriven_low_a: assert property (
		(~fdd_pin_oe_o & fdd_pin_o) == '0)
		else $error("undriven pin carries a high");
endmodule
bind floppy_logical_device_config floppy_cfg_assertions #(
	.PIN_WIDTH(PIN_WIDTH)
) chk_i (.core_clk_i, .arst_n_i, .standby_por_i, .hard_reset_input_i,
	.io_wr_i, .io_rd_i, .io_rvalid_o, .core_fdd_out_i, .fdd_pin_o,
	.fdd_pin_oe_o, .core_pp_fdd_out_i, .pp_fdd_pin_o, .pp_route_i,
	.write_protect_n_i, .drive0_select_n_i, .pp_write_protect_n_i,
	.pp_drive0_select_n_i, .core_write_protect_n_o, .interface_mode_o,
	.drive_type_store_o);

/* File: sim/floppy_logical_device_config_test.sv */
// self-checking bench for the floppy configuration bank.
// assumes the port sits at 0x03f0 until the strap test moves it.
`timescale 1ns/10ps
module floppy_logical_device_config_test;
	logic core_clk_i = 0, arst_n_i = 0, standby_por_i = 0, soft_reset_i = 0;
	logic hard_reset_input_i = 0, config_port_strap_i = 0, pp_route_i = 0;
	logic io_wr_i = 0, io_rd_i = 0, io_rvalid_o, density_o, boot_drive_o;
	logic [15:0] io_addr_i = 0, base = 16'h03f0, p;
	logic [7:0] io_wdata_i = 0, io_rdata_o, drive_type_store_o, d;
	logic [7:0] core_fdd_out_i = 0, core_pp_fdd_out_i = 0;
	logic [7:0] fdd_pin_o, fdd_pin_oe_o, pp_fdd_pin_o;
	logic write_protect_n_i = 1, drive0_select_n_i = 1, core_density_i = 0;
	logic pp_write_protect_n_i = 1, pp_drive0_select_n_i = 1;
	logic core_write_protect_n_o, enhanced_mode_two_o, nonburst_dma_o;
	logic drive0_precomp_disable_o, drive1_precomp_disable_o;
	logic [1:0] interface_mode_o, drive0_type_sel_o, drive0_rate_table_sel_o;
	logic [1:0] drive1_type_sel_o, drive1_rate_table_sel_o;
	logic [7:0] dflt [6] = '{8'h0e, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00};
	logic [7:0] mk [6] = '{8'hcf, 8'h0d, 8'hff, 8'h00, 8'h5b, 8'h5b};
	logic [7:0] m [6];
	int n_mismatch = 0, tests_run = 0;

	floppy_logical_device_config DUT (.core_clk_i, .arst_n_i, .standby_por_i,
		.hard_reset_input_i, .soft_reset_i, .config_port_strap_i, .io_addr_i,
		.io_wr_i, .io_rd_i, .io_wdata_i, .io_rdata_o, .io_rvalid_o,
		.core_fdd_out_i, .fdd_pin_o, .fdd_pin_oe_o, .core_pp_fdd_out_i,
		.pp_fdd_pin_o, .pp_route_i, .write_protect_n_i, .drive0_select_n_i,
		.pp_write_protect_n_i, .pp_drive0_select_n_i, .core_write_protect_n_o,
		.core_density_i, .density_o, .enhanced_mode_two_o, .nonburst_dma_o,
		.interface_mode_o, .drive_type_store_o, .drive0_type_sel_o,
		.drive0_rate_table_sel_o, .drive0_precomp_disable_o, .drive1_type_sel_o,
		.drive1_rate_table_sel_o, .drive1_precomp_disable_o, .boot_drive_o);

	initial begin
		forever #5 core_clk_i = ~core_clk_i;
	end

	task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic io(logic wr, logic [15:0] a, logic [7:0] v);
		@(negedge core_clk_i);
		io_wr_i = wr;
		io_rd_i = !wr;
		io_addr_i = a;
		io_wdata_i = v;
		@(negedge core_clk_i);
		io_wr_i = 0;
		io_rd_i = 0;
	endtask

	task automatic wrreg(logic [7:0] idx, logic [7:0] v);
		io(1, base, idx);
		io(1, base + 16'h0001, v);
	endtask

	task automatic rdreg(logic [7:0] idx, logic [7:0] e);
		io(1, base, idx);
		io(0, base + 16'h0001, 8'h00);
		chk("rvalid", 8'h01, {7'h00, io_rvalid_o});
		chk("rdata", e, io_rdata_o);
	endtask

	task automatic chk_bank();
		for (int i = 0; i < 6; i++) rdreg(8'hf0 + 8'(i), m[i]);
		chk("type", m[2], drive_type_store_o);
		chk("drv0", m[4], {1'b0, drive0_precomp_disable_o, 1'b0,
			drive0_rate_table_sel_o, 1'b0, drive0_type_sel_o});
		chk("drv1", m[5], {1'b0, drive1_precomp_disable_o, 1'b0,
			drive1_rate_table_sel_o, 1'b0, drive1_type_sel_o});
		chk("mode", m[0] & 8'h0f, {4'h0, interface_mode_o,
			nonburst_dma_o, enhanced_mode_two_o});
	endtask

	function automatic logic wp_exp();
		if (pp_route_i)
			return pp_write_protect_n_i & ~(m[1][0] & ~pp_drive0_select_n_i);
		return write_protect_n_i & ~(m[1][0] & ~drive0_select_n_i);
	endfunction

	function automatic logic den_exp();
		if (m[1][3:2] == 2'b10)
			return 1'b1;
		if (m[1][3:2] == 2'b11)
			return 1'b0;
		return core_density_i;
	endfunction

	// level then enable; tristate outranks push-pull
	function automatic logic [15:0] pins();
		if (m[0][7])
			return 16'h0000;
		if (m[0][6])
			return {core_fdd_out_i, 8'hff};
		return {8'h00, ~core_fdd_out_i};
	endfunction

	task automatic end_sim();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		#100000;
		n_mismatch++;
		end_sim();
	end

	initial begin
		m = dflt;
		void'($urandom(39453));
		repeat (8) @(negedge core_clk_i);
		arst_n_i = 1;
		chk_bank();
		chk("boot", 8'h00, {7'h00, boot_drive_o});
		for (int k = 0; k < 3; k++) begin
			for (int i = 0; i < 24; i++) begin
				d = 8'($urandom);
				wrreg(8'hf0 + 8'(i % 6), d);
				m[i % 6] = d & mk[i % 6];
			end
			chk_bank();
			config_port_strap_i = (k == 2);
			@(negedge core_clk_i);
			soft_reset_i = (k == 0);
			hard_reset_input_i = (k == 1);
			standby_por_i = (k == 2);
			@(negedge core_clk_i);
			{soft_reset_i, hard_reset_input_i, standby_por_i} = 3'b000;
			if (k > 0)
				m = dflt;
			if (k == 2)
				base = 16'h0370;
			chk_bank();
		end
		io(0, 16'h03f1, 8'h00);
		chk("old port", 8'h00, {7'h00, io_rvalid_o});
		$display("register and reset test done");
		wrreg(8'h07, 8'h03);
		wrreg(8'hf2, 8'h5a);
		rdreg(8'hf2, 8'h00);
		wrreg(8'h07, 8'h00);
		rdreg(8'hf2, m[2]);
		$display("device select test done");
		// low byte drops bit 0; each byte moves the port at once
		wrreg(8'h26, 8'h61);
		base = 16'h0360;
		rdreg(8'h26, 8'h60);
		wrreg(8'h27, 8'h02);
		base = 16'h0260;
		rdreg(8'h27, 8'h02);
		io(0, 16'h0361, 8'h00);
		chk("moved port", 8'h00, {7'h00, io_rvalid_o});
		$display("relocation test done");
		for (int j = 0; j < 32; j++) begin
			if (j % 4 == 0) begin
				d = {4'h0, 2'(j / 8), 1'b0, 1'(j / 4)};
				wrreg(8'hf1, d);
				m[1] = d;
			end
			@(negedge core_clk_i);
			{pp_route_i, write_protect_n_i, drive0_select_n_i, core_density_i,
				pp_write_protect_n_i, pp_drive0_select_n_i} = 6'($urandom);
			@(negedge core_clk_i);
			chk("wp", {7'h00, wp_exp()}, {7'h00, core_write_protect_n_o});
			chk("den", {7'h00, den_exp()}, {7'h00, density_o});
		end
		$display("protect and density test done");
		for (int j = 0; j < 4; j++) begin
			d = {2'(j), 2'b00, 2'(j), 2'b01};
			wrreg(8'hf0, d);
			m[0] = d;
			@(negedge core_clk_i);
			core_fdd_out_i = 8'($urandom);
			core_pp_fdd_out_i = 8'($urandom);
			@(negedge core_clk_i);
			p = pins();
			chk("pin", p[15:8], fdd_pin_o);
			chk("oe", p[7:0], fdd_pin_oe_o);
			chk("pp", core_pp_fdd_out_i, pp_fdd_pin_o);
			chk("ifm", {6'h00, 2'(j)}, {6'h00, interface_mode_o});
		end
		$display("pin test done");
		end_sim();
	end
endmodule
